// ===== sim/iaf_bus_peer.sv
// Purpose: Other party on the two-wire bus
// Assumes: Open-drain lines with pull-ups, released lines read high
// Notes: Each level held eight clocks, only one line changes per step
module iaf_bus_peer
(
  input  wire logic mclk,
  output logic      scl,
  output logic      sda
);
  timeunit 1ns;
  timeprecision 1ps;
  // Idle bus, both lines released
  initial
  begin
    scl = 1'b1;
    sda = 1'b1;
  end
  // One bus step after a clock edge
  task automatic step(input logic c, input logic d);
    @(posedge mclk);
    scl <= c;
    sda <= d;
    repeat (7) @(posedge mclk);
  endtask
  // Start or repeated start
  task automatic bus_start();
    step(1'b0, sda);
    step(1'b0, 1'b1);
    step(1'b1, 1'b1);
    step(1'b1, 1'b0);
  endtask
  // One data bit, changed while the clock is low
  task automatic bus_bit(input logic b);
    step(1'b0, sda);
    step(1'b0, b);
    step(1'b1, b);
  endtask
  // Byte, first bit sent is the top bit
  task automatic send_byte(input logic [7:0] v);
    for (int i = 7; i >= 0; i--)
      bus_bit(v[i]);
  endtask
endmodule

// ===== sim/iaf_flags_props.sv
// Purpose: Checker for the status flag block
// Assumes: Mode bits are tracked from control writes
// Notes: Bound to every instance of the flag block
module iaf_flags_props
  import iaf_pkg::*;
(
  input wire logic                  mclk,
  input wire logic                  rst_n,
  input wire logic [IAF_ADDR_W-1:0] reg_addr,
  input wire logic [IAF_DATA_W-1:0] reg_wdata,
  input wire logic                  reg_wr,
  input wire logic                  reg_rd,
  input wire logic [IAF_DATA_W-1:0] reg_rdata,
  input wire logic                  rx_full_flag,
  input wire logic                  sync_last_bit,
  input wire logic                  arb_lost_overrun_flag,
  input wire logic                  own_addr_match_flag
);
  logic [7:0] ctrl_q;
  logic       armed_q;
  logic       st_wr;
  logic       st_rd;
  logic       lost;
  logic       match;
  // Status access strobes and short flag names
  assign st_wr = reg_wr && (reg_addr == IAF_OFS_STATUS);
  assign st_rd = reg_rd && (reg_addr == IAF_OFS_STATUS);
  assign lost  = arb_lost_overrun_flag;
  assign match = own_addr_match_flag;
  // Copy of the mode bits
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      ctrl_q <= 8'h00;
    else if (reg_wr && (reg_addr == IAF_OFS_CTRL))
      ctrl_q <= reg_wdata;
  end
  // Read of a set lost flag arms the clear
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      armed_q <= 1'b0;
    else if (st_wr)
      armed_q <= 1'b0;
    else if (st_rd && lost)
      armed_q <= 1'b1;
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////////////////////////////////////////
  rdata_idle_a: assert property (
    !$past(reg_rd) |-> reg_rdata == 8'h00) else $error("Read data not idle");
  status_read_a: assert property (
    $past(st_rd) |-> reg_rdata == {5'h00, $past(lost), $past(match), 1'b0})
    else $error("Status read wrong");
  unmapped_read_a: assert property (
    $past(reg_rd && reg_addr > IAF_OFS_SADDR) |-> reg_rdata == 8'h00)
    else $error("Unmapped read not zero");
  overrun_set_a: assert property (
    ctrl_q[2] && sync_last_bit && rx_full_flag |=> lost) else $error("Overrun missed");
  lost_cause_a: assert property (
    $rose(lost) |-> $past(ctrl_q[0] || (sync_last_bit && rx_full_flag)))
    else $error("Lost set without cause");
  lost_clear_a: assert property (
    $fell(lost) |-> $past(st_wr && !reg_wdata[2] && armed_q)) else $error("Bad lost clear");
  lost_hold_a: assert property (
    lost && !(st_wr && !reg_wdata[2]) |=> lost) else $error("Lost flag dropped");
  match_clear_a: assert property (
    $fell(match) |-> $past(st_wr && !reg_wdata[1])) else $error("Bad match clear");
  match_cause_a: assert property (
    $rose(match) |-> $past(ctrl_q[2:0] == 3'b000)) else $error("Match outside slave rx");
  match_hold_a: assert property (
    match && !(st_wr && !reg_wdata[1]) |=> match) else $error("Match flag dropped");
  // Main scenarios
  lost_seen_c: cover property ($rose(lost) && ctrl_q[0]);
  ovr_seen_c: cover property ($rose(lost) && ctrl_q[2]);
  match_seen_c: cover property ($rose(match));
endmodule

bind iaf_flags iaf_flags_props i_props (.mclk(mclk), .rst_n(rst_n), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .rx_full_flag(rx_full_flag), .sync_last_bit(sync_last_bit),
  .arb_lost_overrun_flag(arb_lost_overrun_flag), .own_addr_match_flag(own_addr_match_flag));

// ===== sim/iaf_flags_tb.sv
// Purpose: Self-checking bench for the status flag block
// Assumes: Peer model drives both bus pins
// Notes: Status reads as {5'b0, lost, match, 1'b0}
module iaf_flags_tb
  import iaf_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic       mclk      = 1'b0;
  logic       rst_n     = 1'b0;
  logic [7:0] reg_addr  = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic       reg_wr    = 1'b0;
  logic       reg_rd    = 1'b0;
  logic [7:0] reg_rdata;
  logic       scl;
  logic       sda;
  logic       drv_lvl   = 1'b1;
  logic       rx_full   = 1'b0;
  logic       last_bit  = 1'b0;
  logic       lost;
  logic       match;
  int         failures    = 0;
  int         checks_done = 0;
  // 100 MHz clock
  initial
  begin
    forever #5 mclk = ~mclk;
  end
  iaf_flags i_iaf_flags (.mclk(mclk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .scl_in(scl), .sda_in(sda), .sda_drive_level(drv_lvl), .rx_full_flag(rx_full),
    .sync_last_bit(last_bit), .arb_lost_overrun_flag(lost), .own_addr_match_flag(match));
  iaf_bus_peer i_iaf_bus_peer (.mclk(mclk), .scl(scl), .sda(sda));
  ////////////////////////////////////////////////////////////////////////////
  // Verdict and end of run
  task automatic end_of_test();
    $display("Checks %0d, failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // Compare and count
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      failures++;
      $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  // One-cycle register write
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask
  // Register read, data checked in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge mclk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata, exp);
  endtask
  // Bounded wait for a flag to rise
  task automatic wait_flag(input logic want_lost);
    int n;
    n = 0;
    while (((want_lost ? lost : match) !== 1'b1) && n < 40)
    begin
      @(posedge mclk);
      n++;
    end
    if ((want_lost ? lost : match) !== 1'b1)
    begin
      failures++;
      $display("Error at %0t: flag wait ran out", $time);
      end_of_test();
    end
  endtask
  // Final-bit pulse with a given receive-full level
  task automatic pulse(input logic full);
    @(posedge mclk);
    rx_full  <= full;
    last_bit <= 1'b1;
    @(posedge mclk);
    last_bit <= 1'b0;
    rx_full  <= 1'b0;
  endtask
  // Drive level change on a clock edge
  task automatic set_drv(input logic v);
    @(posedge mclk);
    drv_lvl <= v;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (20) @(posedge mclk);
    rst_n <= 1'b1;
    rd(IAF_OFS_STATUS, 8'h00);
    rd(IAF_OFS_CTRL, 8'h00);
    rd(8'h07, 8'h00);
    // Slave receive: other address, own address, general call
    wr(IAF_OFS_SADDR, 8'hb4);
    rd(IAF_OFS_SADDR, 8'hb4);
    i_iaf_bus_peer.bus_start();
    i_iaf_bus_peer.send_byte(8'hb6);
    rd(IAF_OFS_STATUS, 8'h00);
    i_iaf_bus_peer.bus_start();
    i_iaf_bus_peer.send_byte(8'hb4);
    wait_flag(1'b0);
    rd(IAF_OFS_STATUS, 8'h02);
    chk({6'h00, lost, match}, 8'h01);
    wr(IAF_OFS_STATUS, 8'h02);
    rd(IAF_OFS_STATUS, 8'h02);
    wr(IAF_OFS_STATUS, 8'h00);
    rd(IAF_OFS_STATUS, 8'h00);
    i_iaf_bus_peer.bus_start();
    i_iaf_bus_peer.send_byte(8'h00);
    wait_flag(1'b0);
    rd(IAF_OFS_STATUS, 8'h02);
    wr(IAF_OFS_STATUS, 8'h00);
    // Slave transmit: own address must not set the match flag
    wr(IAF_OFS_CTRL, 8'h02);
    i_iaf_bus_peer.bus_start();
    i_iaf_bus_peer.send_byte(8'hb4);
    rd(IAF_OFS_STATUS, 8'h00);
    chk({6'h00, lost, match}, 8'h00);
    // Overrun in clocked sync format, then the clearing sequence
    wr(IAF_OFS_CTRL, 8'h04);
    pulse(1'b0);
    rd(IAF_OFS_STATUS, 8'h00);
    pulse(1'b1);
    wr(IAF_OFS_STATUS, 8'h00);
    rd(IAF_OFS_STATUS, 8'h04);
    chk({6'h00, lost, match}, 8'h02);
    wr(IAF_OFS_STATUS, 8'h04);
    rd(IAF_OFS_STATUS, 8'h04);
    wr(IAF_OFS_STATUS, 8'h00);
    rd(IAF_OFS_STATUS, 8'h00);
    // Master: start seen while driving low, then while driving high
    wr(IAF_OFS_CTRL, 8'h01);
    set_drv(1'b0);
    i_iaf_bus_peer.bus_start();
    rd(IAF_OFS_STATUS, 8'h00);
    set_drv(1'b1);
    i_iaf_bus_peer.bus_start();
    wait_flag(1'b1);
    rd(IAF_OFS_STATUS, 8'h04);
    wr(IAF_OFS_STATUS, 8'h00);
    rd(IAF_OFS_STATUS, 8'h00);
    // Master transmit: agreeing bit, then disagreeing bit
    wr(IAF_OFS_CTRL, 8'h03);
    i_iaf_bus_peer.bus_bit(1'b1);
    rd(IAF_OFS_STATUS, 8'h00);
    set_drv(1'b0);
    i_iaf_bus_peer.bus_bit(1'b1);
    wait_flag(1'b1);
    rd(IAF_OFS_STATUS, 8'h04);
    chk({6'h00, lost, match}, 8'h02);
    // Reset in mid-run returns the set flag to zero
    @(posedge mclk);
    rst_n <= 1'b0;
    repeat (2) @(posedge mclk);
    rst_n <= 1'b1;
    rd(IAF_OFS_STATUS, 8'h00);
    chk({6'h00, lost, match}, 8'h00);
    end_of_test();
  end
endmodule

// ===== verilog/iaf_flags.sv
////////////////////////////////////////////////////////////////////////////////
// Purpose : Arbitration-lost/overrun flag and own-address match flag
// Assumes : Data shifting, clock generation and pin drive live elsewhere
// Notes   : Registers on a plain port; read data one cycle after strobe
//
// Summary of operation
// R01: Master transmit: driven vs sampled data mismatch sets lost
// R02: Master: start seen while driving high sets lost
// R03: Sync format: last bit with rx full sets overrun
// R04: Lost flag clears on read-one then write-zero
// R05: Slave receive: own address match sets match flag
// R06: Slave receive: general call also sets match flag
// R07: Match flag is status bit 1, reset zero
// R08: Lost/overrun flag is status bit 2, reset zero
// R09: Writing one never sets either flag
////////////////////////////////////////////////////////////////////////////////
module iaf_flags
  import iaf_pkg::*;
(
  input  wire logic                  mclk,
  input  wire logic                  rst_n,
  // Register port
  input  wire logic [IAF_ADDR_W-1:0] reg_addr,
  input  wire logic [IAF_DATA_W-1:0] reg_wdata,
  input  wire logic                  reg_wr,
  input  wire logic                  reg_rd,
  output logic      [IAF_DATA_W-1:0] reg_rdata,
  // Bus pins, sampled only
  input  wire logic                  scl_in,
  input  wire logic                  sda_in,
  // Same-clock inputs from the shifter
  input  wire logic                  sda_drive_level,
  input  wire logic                  rx_full_flag,
  input  wire logic                  sync_last_bit,
  // Flag outputs
  output logic                       arb_lost_overrun_flag,
  output logic                       own_addr_match_flag
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  logic [IAF_DATA_W-1:0]    rdata_q;
  logic [IAF_DATA_W-1:0]    ctrl_q;
  logic [IAF_DATA_W-1:0]    saddr_q;
  logic                     lost_q;
  logic                     match_q;
  logic                     lost_armed_q;
  iaf_frame_type            frame_q;
  logic [3:0]               bit_cnt_q;
  logic [IAF_DATA_W-1:0]    shift_q;

  logic                     scl_level;
  logic                     scl_rise;
  logic                     sda_level;
  logic                     sda_fall;
  logic                     start_det;
  logic                     master_mode;
  logic                     transmit_mode;
  logic                     sync_format;
  logic [IAF_SA_ADDR_W-1:0] own_slave_addr_field;
  logic                     wr_status;
  logic                     rd_status;
  logic                     set_lost;
  logic                     clr_lost;
  logic                     frame_end;
  logic                     addr_hit;
  logic                     set_match;
  logic                     clr_match;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  iaf_pin_sync #(
    .RST_LEVEL (1'b1)
  ) u_scl_sync (
    .mclk  (mclk),
    .rst_n (rst_n),
    .pin   (scl_in),
    .level (scl_level),
    .rise  (scl_rise),
    .fall  ()
  );

  iaf_pin_sync #(
    .RST_LEVEL (1'b1)
  ) u_sda_sync (
    .mclk  (mclk),
    .rst_n (rst_n),
    .pin   (sda_in),
    .level (sda_level),
    .rise  (),
    .fall  (sda_fall)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Start condition: data falls while clock stays high
  assign start_det = sda_fall & scl_level;

  ////////////////////////////////////////////////////////////////////////////
  // Control and address fields
  assign master_mode          = ctrl_q[IAF_CT_MASTER_BIT];
  assign transmit_mode        = ctrl_q[IAF_CT_TRANSMIT_BIT];
  assign sync_format          = ctrl_q[IAF_CT_SYNC_FMT_BIT];
  assign own_slave_addr_field = saddr_q[IAF_SA_ADDR_LSB +: IAF_SA_ADDR_W];

  // Register access decode
  assign wr_status = reg_wr & (reg_addr == IAF_OFS_STATUS);
  assign rd_status = reg_rd & (reg_addr == IAF_OFS_STATUS);

  ////////////////////////////////////////////////////////////////////////////
  // Control register
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ctrl_q <= IAF_CTRL_RST;
    end
    else if (reg_wr && (reg_addr == IAF_OFS_CTRL))
    begin
      ctrl_q <= reg_wdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Slave address register
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      saddr_q <= IAF_SADDR_RST;
    end
    else if (reg_wr && (reg_addr == IAF_OFS_SADDR))
    begin
      saddr_q <= reg_wdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Arbitration-lost and overrun setting conditions
  always_comb
  begin
    set_lost = 1'b0;
    if (master_mode && transmit_mode && !sync_format && scl_rise &&
        (sda_drive_level != sda_level))
    begin
      set_lost = 1'b1;                                        // R01
    end
    if (master_mode && !sync_format && start_det && sda_drive_level)
    begin
      set_lost = 1'b1;                                        // R02
    end
    if (sync_format && sync_last_bit && rx_full_flag)
    begin
      set_lost = 1'b1;                                        // R03
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Clear only by a zero write after the flag was read as one
  assign clr_lost = wr_status & lost_armed_q &
                    ~reg_wdata[IAF_ST_ARB_LOST_BIT];          // R04 R09

  // Arm on a read that sees the flag set; any status write disarms
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      lost_armed_q <= 1'b0;
    end
    else if (wr_status)
    begin
      lost_armed_q <= 1'b0;
    end
    else if (rd_status && lost_q)
    begin
      lost_armed_q <= 1'b1;                                   // R04
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Arbitration-lost/overrun flag; a set beats a clear in the same cycle
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      lost_q <= IAF_FLAG_RST;                                 // R08
    end
    else if (set_lost)
    begin
      lost_q <= 1'b1;
    end
    else if (clr_lost)
    begin
      lost_q <= 1'b0;                                         // R04
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // First-frame tracker: counts eight clock rises after each start
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      frame_q   <= IAF_FR_IDLE;
      bit_cnt_q <= 4'h0;
      shift_q   <= 8'h00;
    end
    else if (start_det)
    begin
      frame_q   <= IAF_FR_ADDR;
      bit_cnt_q <= 4'h0;
      shift_q   <= 8'h00;
    end
    else
    begin
      case (frame_q)
        IAF_FR_IDLE:
        begin
          bit_cnt_q <= 4'h0;
        end
        IAF_FR_ADDR:
        begin
          if (scl_rise)
          begin
            shift_q   <= {shift_q[IAF_DATA_W-2:0], sda_level};
            bit_cnt_q <= bit_cnt_q + 4'h1;
            if (bit_cnt_q == (IAF_FRAME_BITS - 4'h1))
            begin
              frame_q <= IAF_FR_DONE;
            end
          end
        end
        IAF_FR_DONE:
        begin
          bit_cnt_q <= bit_cnt_q;
        end
        default:
        begin
          frame_q <= IAF_FR_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Address check on the eighth rise; address is the first seven bits
  assign frame_end = (frame_q == IAF_FR_ADDR) & scl_rise & ~start_det &
                     (bit_cnt_q == (IAF_FRAME_BITS - 4'h1));

  always_comb
  begin
    addr_hit = 1'b0;
    if (shift_q[IAF_SA_ADDR_W-1:0] == own_slave_addr_field)
    begin
      addr_hit = 1'b1;                                        // R05
    end
    if (shift_q[IAF_SA_ADDR_W-1:0] == IAF_GEN_CALL_ADDR)
    begin
      addr_hit = 1'b1;                                        // R06
    end
  end

  // Slave receive mode: not master, not transmitting, two-wire format
  assign set_match = frame_end & addr_hit & ~master_mode &
                     ~transmit_mode & ~sync_format;           // R05 R06

  // A zero written to bit 1 clears; a one leaves it alone
  assign clr_match = wr_status & ~reg_wdata[IAF_ST_ADDR_MATCH_BIT];  // R09

  ////////////////////////////////////////////////////////////////////////////
  // Own-address match flag; a set beats a clear in the same cycle
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      match_q <= IAF_FLAG_RST;                                // R07
    end
    else if (set_match)
    begin
      match_q <= 1'b1;
    end
    else if (clr_match)
    begin
      match_q <= 1'b0;                                        // R07
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data, valid only in the cycle after the read strobe
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rdata_q <= 8'h00;
    end
    else
    begin
      rdata_q <= 8'h00;
      if (reg_rd)
      begin
        case (reg_addr)
          IAF_OFS_STATUS:
          begin
            rdata_q[IAF_ST_ARB_LOST_BIT]   <= lost_q;         // R08
            rdata_q[IAF_ST_ADDR_MATCH_BIT] <= match_q;        // R07
          end
          IAF_OFS_CTRL:
          begin
            rdata_q <= ctrl_q;
          end
          IAF_OFS_SADDR:
          begin
            rdata_q <= saddr_q;
          end
          default:
          begin
            rdata_q <= 8'h00;
          end
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs straight from flip-flops
  assign reg_rdata             = rdata_q;
  assign arb_lost_overrun_flag = lost_q;
  assign own_addr_match_flag   = match_q;

endmodule

// ===== verilog/iaf_pin_sync.sv
////////////////////////////////////////////////////////////////////////////////
// Purpose : Three-stage synchroniser with agreement filter for one bus pin
// Assumes : Pin is asynchronous to mclk
// Notes   : Level changes only when stages two and three agree
////////////////////////////////////////////////////////////////////////////////
module iaf_pin_sync
  import iaf_pkg::*;
#(
  parameter logic RST_LEVEL = 1'b1
)
(
  input  wire logic mclk,
  input  wire logic rst_n,
  input  wire logic pin,
  output logic      level,
  output logic      rise,
  output logic      fall
);

  logic s1_q;
  logic s2_q;
  logic s3_q;
  logic level_q;
  logic rise_q;
  logic fall_q;

  ////////////////////////////////////////////////////////////////////////////
  // Synchroniser chain; first stage feeds only the second
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s1_q <= RST_LEVEL;
      s2_q <= RST_LEVEL;
      s3_q <= RST_LEVEL;
    end
    else
    begin
      s1_q <= pin;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Filtered level and one-cycle edge pulses
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      level_q <= RST_LEVEL;
      rise_q  <= 1'b0;
      fall_q  <= 1'b0;
    end
    else
    begin
      rise_q <= 1'b0;
      fall_q <= 1'b0;
      if ((s2_q == s3_q) && (s3_q != level_q))
      begin
        level_q <= s3_q;
        rise_q  <= s3_q;
        fall_q  <= ~s3_q;
      end
    end
  end

  assign level = level_q;
  assign rise  = rise_q;
  assign fall  = fall_q;

endmodule

// ===== verilog/iaf_pkg.sv
////////////////////////////////////////////////////////////////////////////////
// Purpose : Shared constants and types for the two-wire status flag block
// Assumes : Register port with 8-bit address and 8-bit data
// Notes   : Offsets are word indices on the plain register port
////////////////////////////////////////////////////////////////////////////////
package iaf_pkg;

  // Register port widths
  localparam int unsigned IAF_ADDR_W = 8;
  localparam int unsigned IAF_DATA_W = 8;

  // Register offsets
  localparam logic [7:0] IAF_OFS_STATUS = 8'h00;
  localparam logic [7:0] IAF_OFS_CTRL   = 8'h01;
  localparam logic [7:0] IAF_OFS_SADDR  = 8'h02;

  // Status register field positions
  localparam int unsigned IAF_ST_ADDR_MATCH_BIT = 1;
  localparam int unsigned IAF_ST_ARB_LOST_BIT   = 2;

  // Control register field positions
  localparam int unsigned IAF_CT_MASTER_BIT   = 0;
  localparam int unsigned IAF_CT_TRANSMIT_BIT = 1;
  localparam int unsigned IAF_CT_SYNC_FMT_BIT = 2;

  // Slave address register: own address in bits 7..1
  localparam int unsigned IAF_SA_ADDR_LSB = 1;
  localparam int unsigned IAF_SA_ADDR_W   = 7;

  // Values after reset
  localparam logic [7:0] IAF_CTRL_RST  = 8'h00;
  localparam logic [7:0] IAF_SADDR_RST = 8'h00;
  localparam logic       IAF_FLAG_RST  = 1'b0;

  // General call address in the first frame
  localparam logic [6:0] IAF_GEN_CALL_ADDR = 7'h00;

  // Address bits plus direction bit in the first frame
  localparam logic [3:0] IAF_FRAME_BITS = 4'h8;

  // Pin synchroniser depth
  localparam int unsigned IAF_SYNC_STAGES = 3;

  // First-frame tracker states, Gray coded along idle, address, done
  typedef enum logic [1:0]
  {
    IAF_FR_IDLE = 2'b00,
    IAF_FR_ADDR = 2'b01,
    IAF_FR_DONE = 2'b11
  } iaf_frame_type;

endpackage
